// [rtl/cic_irq_ctrl.sv]
/*
  Interrupt control for a four-phase single-issue core: event flags,
  enable gating, entry sequencing with context save, return handling,
  and an AXI4-Lite register slave with a sticky event status interrupt.
  Assumes the core reports instruction-cycle ends and return execution.
*/
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] any reset clears global, group and individual enables
// [R2] vector only when global and source enables set; group enable for peripherals
// [R3] event flags set regardless of any enable
// [R4] entry flushes prefetch, clears global enable, pushes pc, saves context, vectors 0004h
// [R5] with global enable clear, new events flag but never redirect
// [R6] flags set while disabled stay pending and fire once global enable returns
// [R7] return pops address, restores shadow context, sets global enable
// [R8] firmware polls flags to find the source; one shared vector
// [R9] firmware clears serviced flags before return, else immediate re-entry
// [R10] synchronous events reach the vector in three or four instruction cycles
// [R11] asynchronous events reach the vector in three to five instruction cycles
// [R12] external pin flag is set only in phase four or phase one
// [R13] context: accumulator, status except timeout/powerdown, bank, pointers, pc high latch
// [R14] external pin edge: rising when edge select is one, falling when zero
// [R15] request is or of flag-enable pairs, peripherals group gated, all global gated
// [R16] multi-cycle instruction finishes, then no-operation cycles until vector fetch
module cic_irq_ctrl
  import cic_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  // axi4-lite slave
  input wire logic [cic_pkg::CIC_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [cic_pkg::CIC_DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [cic_pkg::CIC_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [cic_pkg::CIC_DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // event sources
  input wire logic i_tmr_ovf,
  input wire logic i_ioc_any,
  input wire logic i_ext_pin,
  input wire logic [cic_pkg::CIC_PERIPH_W-1:0] i_pevt_a,
  input wire logic [cic_pkg::CIC_PERIPH_W-1:0] i_pevt_b,
  // core sequencer
  input wire logic i_instr_last,
  input wire logic i_ret_instr,
  input wire logic [cic_pkg::CIC_PC_W-1:0] i_pc,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_status,
  input wire logic [4:0] i_bank_select_reg,
  input wire logic [15:0] i_ptr0,
  input wire logic [15:0] i_ptr1,
  input wire logic [6:0] i_pc_high_latch,
  output logic [1:0] o_phase,
  output logic o_flush,
  output logic o_push,
  output logic [cic_pkg::CIC_PC_W-1:0] o_push_pc,
  output logic o_pop,
  output logic o_load_vector,
  output logic [cic_pkg::CIC_PC_W-1:0] o_vector_pc,
  output logic o_insert_nop,
  output logic o_restore,
  output logic [7:0] o_rst_acc,
  output logic [7:0] o_rst_status,
  output logic [4:0] o_rst_bank,
  output logic [15:0] o_rst_ptr0,
  output logic [15:0] o_rst_ptr1,
  output logic [6:0] o_rst_pc_high_latch,
  // block interrupt
  output logic o_irq
);

  import cic_pkg::*;

  // ********************************************
  // declarations
  // ********************************************
  logic [1:0] phase_q;
  cic_state_e state_q;
  logic [7:0] irq_control_reg_q;
  logic [7:0] peripheral_flag_reg_a_q;
  logic [7:0] peripheral_flag_reg_b_q;
  logic [7:0] peripheral_enable_reg_a_q;
  logic [7:0] peripheral_enable_reg_b_q;
  logic ext_pin_edge_select_q;
  logic [CIC_EVT_W-1:0] evt_status_q;
  logic [CIC_EVT_W-1:0] evt_mask_q;
  logic ext_prev_q;
  logic ext_hit_q;
  logic ext_armed_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane0_q;
  logic bus_wr;
  logic wr_ctl;
  logic wr_fa;
  logic wr_fb;
  logic [7:0] wv;
  logic ext_edge;
  logic ext_commit;
  logic core_req;
  logic periph_req;
  logic irq_req;
  logic any_flag_set;
  logic enter;
  logic ret;
  logic [63:0] shadow_wdata;
  logic [63:0] shadow_rdata;
  logic [7:0] rd_byte;
  logic rd_hit;

  // ********************************************
  // instruction phase counter
  // ********************************************
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_q <= CIC_Q1;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign o_phase = phase_q;

  // ********************************************
  // external pin edge detect
  // ********************************************
  // edge is remembered until a Q4/Q1 slot lets it into the flag
  assign ext_edge = ext_armed_q & (ext_pin_edge_select_q ? (i_ext_pin & ~ext_prev_q)
    : (~i_ext_pin & ext_prev_q)); // [R14]
  assign ext_commit = (phase_q == CIC_Q4) || (phase_q == CIC_Q1); // [R12]

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_prev_q <= 1'b0;
      ext_hit_q <= 1'b0;
      ext_armed_q <= 1'b0;
    end else begin
      ext_armed_q <= 1'b1;
      ext_prev_q <= i_ext_pin;
      if (ext_commit) begin
        ext_hit_q <= 1'b0;
      end else if (ext_edge) begin
        ext_hit_q <= 1'b1;
      end
    end
  end

  // ********************************************
  // request gating
  // ********************************************
  assign core_req = (irq_control_reg_q[CIC_BIT_TMR_EN] & irq_control_reg_q[CIC_BIT_TMR_FLAG])
    | (irq_control_reg_q[CIC_BIT_EXT_EN] & irq_control_reg_q[CIC_BIT_EXT_FLAG])
    | (irq_control_reg_q[CIC_BIT_IOC_EN] & irq_control_reg_q[CIC_BIT_IOC_FLAG]); // [R15]
  assign periph_req = irq_control_reg_q[CIC_BIT_PERIPHERAL_GROUP_IRQ_ENABLE]
    & (|(peripheral_flag_reg_a_q & peripheral_enable_reg_a_q)
    | |(peripheral_flag_reg_b_q & peripheral_enable_reg_b_q)); // [R2] [R15]
  // pending flags wait for the global enable to return
  assign irq_req = irq_control_reg_q[CIC_BIT_GIE] & (core_req | periph_req); // [R2] [R6]
  assign any_flag_set = |irq_control_reg_q[2:0] | |peripheral_flag_reg_a_q
    | |peripheral_flag_reg_b_q;

  // ********************************************
  // entry sequencer
  // ********************************************
  // request is sampled in Q1; entry commits at the end of the last
  // cycle of the running instruction, then two no-op cycles follow
  assign enter = (state_q == CIC_ST_FINISH) && (phase_q == CIC_Q4) && i_instr_last; // [R16]
  assign ret = i_ret_instr && (state_q == CIC_ST_IDLE);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= CIC_ST_IDLE;
    end else begin
      case (state_q)
        CIC_ST_IDLE: begin
          if (phase_q == CIC_Q1 && irq_req) begin // [R5]
            state_q <= CIC_ST_FINISH;
          end
        end
        CIC_ST_FINISH: begin
          if (enter) begin // [R16]
            state_q <= CIC_ST_NOP1;
          end
        end
        CIC_ST_NOP1: begin
          if (phase_q == CIC_Q4) begin
            state_q <= CIC_ST_NOP2;
          end
        end
        CIC_ST_NOP2: begin
          if (phase_q == CIC_Q4) begin // [R10] [R11]
            state_q <= CIC_ST_IDLE;
          end
        end
        default: begin
          state_q <= CIC_ST_IDLE;
        end
      endcase
    end
  end

  assign o_insert_nop = (state_q == CIC_ST_NOP1) || (state_q == CIC_ST_NOP2); // [R16]

  // ********************************************
  // core strobes
  // ********************************************
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_flush <= 1'b0;
      o_push <= 1'b0;
      o_push_pc <= '0;
      o_load_vector <= 1'b0;
      o_vector_pc <= '0;
      o_pop <= 1'b0;
    end else begin
      o_flush <= enter; // [R4]
      o_push <= enter; // [R4]
      if (enter) begin
        o_push_pc <= i_pc; // [R4]
      end
      o_load_vector <= (state_q == CIC_ST_NOP2) && (phase_q == CIC_Q4); // [R4]
      o_vector_pc <= CIC_VECTOR; // [R4]
      o_pop <= ret; // [R7]
    end
  end

  // ********************************************
  // context save and restore
  // ********************************************
  assign shadow_wdata = {i_pc_high_latch[6] ? 1'b1 : 1'b0, i_pc_high_latch[5:0],
    1'b0, i_ptr1, i_ptr0, 3'h0, i_bank_select_reg, i_status, i_acc}; // [R13]

  cic_shadow_mem #(
    .WORDS(CIC_SHADOW_WORDS)
  ) u_shadow (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_wr(enter), // [R4]
    .i_wdata({shadow_wdata[63:57], 1'b0, shadow_wdata[55:0]}),
    .o_rdata(shadow_rdata)
  );

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_restore <= 1'b0;
      o_rst_acc <= 8'h00;
      o_rst_status <= 8'h00;
      o_rst_bank <= 5'h00;
      o_rst_ptr0 <= 16'h0000;
      o_rst_ptr1 <= 16'h0000;
      o_rst_pc_high_latch <= 7'h00;
    end else begin
      o_restore <= ret; // [R7]
      if (ret) begin
        o_rst_acc <= shadow_rdata[7:0]; // [R13]
        // timeout and power-down stay as the core holds them now
        o_rst_status <= shadow_rdata[15:8];
        o_rst_status[CIC_STATUS_TO] <= i_status[CIC_STATUS_TO]; // [R13]
        o_rst_status[CIC_STATUS_PD] <= i_status[CIC_STATUS_PD]; // [R13]
        o_rst_bank <= shadow_rdata[20:16];
        o_rst_ptr0 <= shadow_rdata[39:24];
        o_rst_ptr1 <= shadow_rdata[55:40];
        o_rst_pc_high_latch <= shadow_rdata[63:57];
      end
    end
  end

  // ********************************************
  // axi4-lite write path
  // ********************************************
  assign o_awready = !aw_have_q && !o_bvalid;
  assign o_wready = !w_have_q && !o_bvalid;
  assign bus_wr = aw_have_q && w_have_q && w_lane0_q;
  assign wv = w_byte_q;
  assign wr_ctl = bus_wr && (aw_addr_q == CIC_OFS_IRQ_CONTROL);
  assign wr_fa = bus_wr && (aw_addr_q == CIC_OFS_PFLAG_A);
  assign wr_fb = bus_wr && (aw_addr_q == CIC_OFS_PFLAG_B);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= CIC_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {i_awaddr[7:2], 2'h0};
      end
      if (i_wvalid && o_wready) begin
        w_have_q <= 1'b1;
        w_byte_q <= i_wdata[7:0];
        w_lane0_q <= i_wstrb[0];
      end
      if (aw_have_q && w_have_q) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (aw_addr_q > CIC_OFS_EVT_MASK) ? CIC_RESP_SLVERR : CIC_RESP_OKAY;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // ********************************************
  // irq_control_reg: enables and core flags
  // ********************************************
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_control_reg_q <= CIC_RST_IRQ_CONTROL; // [R1]
    end else begin
      if (wr_ctl) begin
        irq_control_reg_q[7:1] <= wv[7:1];
      end
      // entry clears global enable, return sets it; both beat a bus write
      if (enter) begin
        irq_control_reg_q[CIC_BIT_GIE] <= 1'b0; // [R4] [R5]
      end else if (ret) begin
        irq_control_reg_q[CIC_BIT_GIE] <= 1'b1; // [R7]
      end
      // set beats a same-cycle firmware clear
      if (i_tmr_ovf) begin
        irq_control_reg_q[CIC_BIT_TMR_FLAG] <= 1'b1; // [R3]
      end
      if (ext_commit && (ext_edge || ext_hit_q)) begin
        irq_control_reg_q[CIC_BIT_EXT_FLAG] <= 1'b1; // [R3] [R12]
      end
      // change flag follows its summary input and is read-only
      irq_control_reg_q[CIC_BIT_IOC_FLAG] <= i_ioc_any; // [R3]
    end
  end

  // ********************************************
  // peripheral flags and enables
  // ********************************************
  genvar gb;
  generate
    for (gb = 0; gb < CIC_PERIPH_W; gb++) begin : g_pflag
      always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
          peripheral_flag_reg_a_q[gb] <= CIC_RST_PFLAG[gb];
          peripheral_flag_reg_b_q[gb] <= CIC_RST_PFLAG[gb];
        end else begin
          if (i_pevt_a[gb]) begin
            peripheral_flag_reg_a_q[gb] <= 1'b1; // [R3]
          end else if (wr_fa) begin
            peripheral_flag_reg_a_q[gb] <= wv[gb];
          end
          if (i_pevt_b[gb]) begin
            peripheral_flag_reg_b_q[gb] <= 1'b1; // [R3]
          end else if (wr_fb) begin
            peripheral_flag_reg_b_q[gb] <= wv[gb];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      peripheral_enable_reg_a_q <= CIC_RST_PEN; // [R1]
      peripheral_enable_reg_b_q <= CIC_RST_PEN; // [R1]
      ext_pin_edge_select_q <= CIC_RST_EDGE_SEL;
      evt_mask_q <= CIC_RST_EVT;
    end else begin
      if (bus_wr && aw_addr_q == CIC_OFS_PEN_A) begin
        peripheral_enable_reg_a_q <= wv;
      end
      if (bus_wr && aw_addr_q == CIC_OFS_PEN_B) begin
        peripheral_enable_reg_b_q <= wv;
      end
      if (bus_wr && aw_addr_q == CIC_OFS_OPTION) begin
        ext_pin_edge_select_q <= wv[CIC_BIT_EDGE_SEL];
      end
      if (bus_wr && aw_addr_q == CIC_OFS_EVT_MASK) begin
        evt_mask_q <= wv[CIC_EVT_W-1:0];
      end
    end
  end

  // ********************************************
  // sticky event status, write one to clear
  // ********************************************
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      evt_status_q <= CIC_RST_EVT;
    end else begin
      if (bus_wr && aw_addr_q == CIC_OFS_EVT_STATUS) begin
        evt_status_q <= evt_status_q & ~wv[CIC_EVT_W-1:0];
      end
      if (enter) begin
        evt_status_q[CIC_EVT_ENTRY] <= 1'b1;
      end
      if (ret) begin
        evt_status_q[CIC_EVT_RETURN] <= 1'b1;
      end
      // flag standing while the global enable is off: held, not vectored
      if (any_flag_set && !irq_control_reg_q[CIC_BIT_GIE]) begin
        evt_status_q[CIC_EVT_HELD] <= 1'b1; // [R5]
      end
    end
  end

  assign o_irq = |(evt_status_q & evt_mask_q);

  // ********************************************
  // axi4-lite read path
  // ********************************************
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case ({i_araddr[7:2], 2'h0})
      CIC_OFS_IRQ_CONTROL: rd_byte = irq_control_reg_q; // [R8]
      CIC_OFS_PFLAG_A: rd_byte = peripheral_flag_reg_a_q; // [R8]
      CIC_OFS_PFLAG_B: rd_byte = peripheral_flag_reg_b_q; // [R8]
      CIC_OFS_PEN_A: rd_byte = peripheral_enable_reg_a_q;
      CIC_OFS_PEN_B: rd_byte = peripheral_enable_reg_b_q;
      CIC_OFS_OPTION: rd_byte = {1'b0, ext_pin_edge_select_q, 6'h00};
      CIC_OFS_EVT_STATUS: rd_byte = {5'h00, evt_status_q};
      CIC_OFS_EVT_MASK: rd_byte = {5'h00, evt_mask_q};
      CIC_OFS_SEQ_STATE: rd_byte = {2'h0, phase_q, state_q};
      default: rd_hit = 1'b0;
    endcase
  end

  assign o_arready = !o_rvalid;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= CIC_RESP_OKAY;
    end else begin
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata <= {24'h00_0000, rd_byte};
        o_rresp <= rd_hit ? CIC_RESP_OKAY : CIC_RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [include/cic_pkg.sv]
/*
  Shared constants of the interrupt control block: register byte offsets,
  field positions, reset values, sequencer states and phase timing.
  Assumes a 32-bit AXI4-Lite register bus and an 8-bit data path core.
*/
`default_nettype none
package cic_pkg;

  // ********************************************
  // bus and data widths
  // ********************************************
  localparam int unsigned CIC_ADDR_W = 8;
  localparam int unsigned CIC_DATA_W = 32;
  localparam int unsigned CIC_PC_W = 15;
  localparam int unsigned CIC_SHADOW_WORDS = 8;
  localparam int unsigned CIC_PERIPH_W = 8;

  // ********************************************
  // register byte offsets
  // ********************************************
  localparam logic [7:0] CIC_OFS_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] CIC_OFS_PFLAG_A = 8'h04;
  localparam logic [7:0] CIC_OFS_PFLAG_B = 8'h08;
  localparam logic [7:0] CIC_OFS_PEN_A = 8'h0C;
  localparam logic [7:0] CIC_OFS_PEN_B = 8'h10;
  localparam logic [7:0] CIC_OFS_OPTION = 8'h14;
  localparam logic [7:0] CIC_OFS_EVT_STATUS = 8'h18;
  localparam logic [7:0] CIC_OFS_EVT_MASK = 8'h1C;
  localparam logic [7:0] CIC_OFS_SEQ_STATE = 8'h20;

  // ********************************************
  // irq_control_reg fields and the option register edge select bit
  // ********************************************
  localparam int unsigned CIC_BIT_GIE = 7;
  localparam int unsigned CIC_BIT_PERIPHERAL_GROUP_IRQ_ENABLE = 6;
  localparam int unsigned CIC_BIT_TMR_EN = 5;
  localparam int unsigned CIC_BIT_EXT_EN = 4;
  localparam int unsigned CIC_BIT_IOC_EN = 3;
  localparam int unsigned CIC_BIT_TMR_FLAG = 2;
  localparam int unsigned CIC_BIT_EXT_FLAG = 1;
  localparam int unsigned CIC_BIT_IOC_FLAG = 0;
  localparam int unsigned CIC_BIT_EDGE_SEL = 6;

  // ********************************************
  // event status bits
  // ********************************************
  localparam int unsigned CIC_EVT_ENTRY = 0;
  localparam int unsigned CIC_EVT_RETURN = 1;
  localparam int unsigned CIC_EVT_HELD = 2;
  localparam int unsigned CIC_EVT_W = 3;

  // ********************************************
  // reset values
  // ********************************************
  localparam logic [7:0] CIC_RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] CIC_RST_PFLAG = 8'h00;
  localparam logic [7:0] CIC_RST_PEN = 8'h00;
  localparam logic CIC_RST_EDGE_SEL = 1'b1;
  localparam logic [2:0] CIC_RST_EVT = 3'h0;

  // ********************************************
  // core sequencing
  // ********************************************
  localparam logic [14:0] CIC_VECTOR = 15'h0004;
  localparam logic [1:0] CIC_Q1 = 2'h0;
  localparam logic [1:0] CIC_Q4 = 2'h3;
  localparam int unsigned CIC_STATUS_TO = 4;
  localparam int unsigned CIC_STATUS_PD = 3;
  localparam logic [1:0] CIC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CIC_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    CIC_ST_IDLE = 4'b0001,
    CIC_ST_FINISH = 4'b0010,
    CIC_ST_NOP1 = 4'b0100,
    CIC_ST_NOP2 = 4'b1000
  } cic_state_e;

endpackage
`default_nettype wire

// [rtl/cic_shadow_mem.sv]
/*
  Shadow context store: a bank of byte entries written together on
  interrupt entry; every entry is read out through its own register.
  Assumes the write strobe is a one-clock pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module cic_shadow_mem #(
  parameter int unsigned WORDS = 8
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_wr,
  input wire logic [8*WORDS-1:0] i_wdata,
  output logic [8*WORDS-1:0] o_rdata
);

  logic [7:0] mem_q [WORDS];

  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_entry
      always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
          mem_q[gi] <= 8'h00;
          o_rdata[8*gi +: 8] <= 8'h00;
        end else begin
          if (i_wr) begin
            mem_q[gi] <= i_wdata[8*gi +: 8];
          end
          o_rdata[8*gi +: 8] <= mem_q[gi];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [dv/cic_core_model.sv]
/* Core model: four-phase sequencer ending instructions, pc, live context.
   Assumes it follows the block's phase count. */
`timescale 1ns/1ps
`default_nettype none
module cic_core_model (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_slow,
  input wire logic [1:0] i_phase,
  input wire logic i_load_vector,
  output logic o_instr_last,
  output logic [14:0] o_pc,
  output logic [7:0] o_acc,
  output logic [7:0] o_status
);
  // ****
  // sequencer
  // ****
  logic [1:0] cyc_q;
  // slow mode: three-cycle instructions
  assign o_instr_last = !i_slow || cyc_q == 2'h2;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cyc_q <= 2'h0;
      {o_pc, o_acc, o_status} <= {15'h0100, 8'h3C, 8'hA5};
    end else if (i_load_vector) begin
      // handler scribbles on context
      {o_pc, o_acc, o_status} <= {15'h0004, 8'hC3, 8'h5A};
    end else if (i_phase == 2'h3) begin
      cyc_q <= o_instr_last ? 2'h0 : cyc_q + 2'h1;
      o_pc <= o_pc + {14'h0, o_instr_last};
    end
  end
endmodule
`default_nettype wire

// [dv/cic_irq_ctrl_sva.sv]
/* Checker of cic_irq_ctrl entry, nop run and return strobes.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module cic_irq_ctrl_sva
  import cic_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ret_instr,
  input wire logic [14:0] i_pc,
  input wire logic [7:0] i_status,
  input wire logic [1:0] o_phase,
  input wire logic o_flush,
  input wire logic o_push,
  input wire logic [14:0] o_push_pc,
  input wire logic o_pop,
  input wire logic o_restore,
  input wire logic o_load_vector,
  input wire logic [14:0] o_vector_pc,
  input wire logic o_insert_nop,
  input wire logic [7:0] o_rst_status
);
  // ****
  // properties
  // ****
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  vec_load_a: assert property (o_load_vector |->
    o_vector_pc == CIC_VECTOR && o_phase == CIC_Q1)
    else $error("vector load off");
  entry_strobe_a: assert property (o_push |-> o_flush && o_insert_nop)
    else $error("entry strobes apart");
  push_pc_a: assert property (o_push |-> o_push_pc == $past(i_pc))
    else $error("pushed pc wrong");
  nop_run_a: assert property (o_push |->
    o_insert_nop [*8] ##1 (o_load_vector && !o_insert_nop))
    else $error("nop run wrong");
  nop_cause_a: assert property ($rose(o_insert_nop) |-> o_push)
    else $error("nop without entry");
  ret_pop_a: assert property ($rose(i_ret_instr) && !o_insert_nop |=> o_pop && o_restore)
    else $error("return not popped");
  pop_once_a: assert property (o_pop |=> !o_pop && !o_restore)
    else $error("pop too long");
  rst_live_a: assert property (o_restore |-> o_rst_status[4:3] == i_status[4:3])
    else $error("status bits restored");
  cover property (o_push);
  cover property (o_pop);
  cover property (o_load_vector);
endmodule
bind cic_irq_ctrl cic_irq_ctrl_sva u_sva (.*);
`default_nettype wire

// [dv/cic_irq_ctrl_tb_top.sv]
/* Testbench of cic_irq_ctrl: AXI4-Lite master, event stimulus, core model.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module cic_irq_ctrl_tb_top;
  import cic_pkg::*;
  typedef struct packed {logic [7:0] a, w, r; logic [1:0] s;} cic_row_s;
  logic i_mclk = '0, i_rstn = '0, i_awvalid = '0, i_wvalid = '0, i_bready = '0, i_arvalid = '0;
  logic i_rready = '0, i_tmr_ovf = '0, i_ioc_any = '0, i_ext_pin = '0, i_ret_instr = '0, slow = '0;
  logic i_instr_last, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_flush, o_push;
  logic o_pop, o_load_vector, o_insert_nop, o_restore, o_irq, ha, hw, hr, hb;
  logic [7:0] i_awaddr = '0, i_araddr = '0, i_pevt_a = '0, i_pevt_b = '0, i_acc, i_status;
  logic [7:0] o_rst_acc, o_rst_status, rd;
  logic [31:0] i_wdata = '0, o_rdata;
  logic [1:0] o_bresp, o_rresp, o_phase, rs;
  logic [14:0] i_pc, o_push_pc, o_vector_pc;
  logic [15:0] i_ptr0 = 16'h1234, i_ptr1 = 16'h5678, o_rst_ptr0, o_rst_ptr1;
  logic [6:0] i_pc_high_latch = 7'h2A, o_rst_pc_high_latch;
  logic [4:0] i_bank_select_reg = 5'h15, o_rst_bank;
  logic [3:0] i_wstrb = 4'hF;
  int n_errors = 0, tests_run = 0, n_push = 0, n, k;
  cic_row_s rows [4] = '{'{CIC_OFS_PEN_A, 8'h04, 8'h04, CIC_RESP_OKAY},
    '{CIC_OFS_EVT_MASK, 8'h03, 8'h03, CIC_RESP_OKAY},
    '{CIC_OFS_OPTION, 8'h40, 8'h40, CIC_RESP_OKAY}, '{8'h24, 8'hFF, 8'h00, CIC_RESP_SLVERR}};
  always #10 i_mclk = ~i_mclk;
  always @(negedge i_mclk) if (o_push === 1'b1) n_push++;
  cic_irq_ctrl uut (.*);
  cic_core_model u_core (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_slow(slow), .i_phase(o_phase),
    .i_load_vector(o_load_vector), .o_instr_last(i_instr_last), .o_pc(i_pc), .o_acc(i_acc),
    .o_status(i_status));
  // ****
  // tasks
  // ****
  task summarize();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task bound(input int c);
    if (c >= 60) begin
      n_errors++;
      summarize();
    end
  endtask
  // handshakes seen at negedge, released at next posedge
  task xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    {i_awaddr, i_araddr, i_wdata} <= {a, a, 24'h0, d};
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} <= {we, we, we, !we, !we};
    for (k = 0; k < 60; k++) begin
      @(negedge i_mclk);
      {ha, hw, hr} = {i_awvalid && o_awready, i_wvalid && o_wready, i_arvalid && o_arready};
      hb = (i_bready && o_bvalid) || (i_rready && o_rvalid);
      {rs, rd} = we ? {o_bresp, 8'h00} : {o_rresp, o_rdata[7:0]};
      @(posedge i_mclk);
      {i_awvalid, i_wvalid, i_arvalid} <= {i_awvalid && !ha, i_wvalid && !hw, i_arvalid && !hr};
      {i_bready, i_rready} <= {i_bready && !hb, i_rready && !hb};
      if (hb) break;
    end
    bound(k);
  endtask
  task rst_chk(input int c);
    i_rstn <= 1'b0;
    repeat (c) @(posedge i_mclk);
    i_rstn <= 1'b1;
    xfer(0, CIC_OFS_IRQ_CONTROL, '0);
    `CHK("ctrl reset", 8'h00, rd)
    $display("test reset done");
  endtask
  task tmr_pulse();
    @(posedge i_mclk);
    i_tmr_ovf <= 1'b1;
    @(posedge i_mclk);
    i_tmr_ovf <= 1'b0;
  endtask
  task ret_pulse();
    @(posedge i_mclk);
    i_ret_instr <= 1'b1;
    @(posedge i_mclk);
    i_ret_instr <= 1'b0;
    @(negedge i_mclk);
    `CHK("pop", 1'b1, o_pop)
  endtask
  task quiet(input int p);
    repeat (40) @(posedge i_mclk);
    `CHK("entries", p, n_push)
  endtask
  task wait_vec();
    for (n = 0; n < 60; n++) begin
      @(negedge i_mclk);
      if (o_load_vector === 1'b1) break;
    end
    bound(n);
  endtask
  initial begin
    rst_chk(8);
    foreach (rows[i]) begin
      xfer(1, rows[i].a, rows[i].w);
      `CHK("bresp", rows[i].s, rs)
      xfer(0, rows[i].a, '0);
      `CHK("rdata", rows[i].r, rd)
      `CHK("rresp", rows[i].s, rs)
    end
    $display("test table done");
    {i_ioc_any, i_ext_pin, i_pevt_a, i_pevt_b} <= {2'b11, 16'h0480};
    tmr_pulse();
    {i_ioc_any, i_pevt_a, i_pevt_b} <= '0;
    repeat (4) @(posedge i_mclk);
    xfer(0, CIC_OFS_IRQ_CONTROL, '0);
    `CHK("flags", 8'h06, rd)
    xfer(0, CIC_OFS_PFLAG_B, '0);
    `CHK("pflag", 8'h80, rd)
    xfer(1, CIC_OFS_IRQ_CONTROL, 8'h80);
    quiet(0);
    xfer(1, CIC_OFS_IRQ_CONTROL, 8'hC0);
    wait_vec();
    xfer(0, CIC_OFS_IRQ_CONTROL, '0);
    `CHK("gie off", 8'h40, rd)
    @(negedge i_mclk);
    `CHK("irq", 1'b1, o_irq)
    xfer(1, CIC_OFS_EVT_MASK, '0);
    @(negedge i_mclk);
    `CHK("irq masked", 1'b0, o_irq)
    xfer(1, CIC_OFS_EVT_STATUS, 8'h07);
    xfer(1, CIC_OFS_EVT_MASK, 8'h03);
    @(negedge i_mclk);
    `CHK("irq cleared", 1'b0, o_irq)
    $display("test entry done");
    xfer(1, CIC_OFS_IRQ_CONTROL, 8'h60);
    tmr_pulse();
    quiet(1);
    xfer(0, CIC_OFS_IRQ_CONTROL, '0);
    `CHK("flag kept", 8'h64, rd)
    slow <= 1'b1;
    ret_pulse();
    `CHK("ctx", {8'h3C, 5'h15, 7'h2A}, {o_rst_acc, o_rst_bank, o_rst_pc_high_latch})
    `CHK("ptrs", {16'h1234, 16'h5678}, {o_rst_ptr0, o_rst_ptr1})
    `CHK("status", 8'hBD, o_rst_status)
    wait_vec();
    slow <= 1'b0;
    xfer(1, CIC_OFS_PFLAG_A, '0);
    xfer(1, CIC_OFS_IRQ_CONTROL, 8'h60);
    ret_pulse();
    quiet(2);
    $display("test return done");
    tmr_pulse();
    wait_vec();
    `CHK("latency", 1'b1, n >= 11 && n <= 19)
    $display("test latency done");
    rst_chk(2);
    summarize();
  end
endmodule
`default_nettype wire
